/* File: hdl/sarseq_top.sv */
// Purpose: Digital sequencer for a 10-bit eight-input SAR converter
// Assumes: APB slave, pclk is the CPU clock, comparator is analog
// Notes:   Overview of operation below
//
// Overview of operation
// - Convert one of eight inputs, 10 bits
// - Control bits 6..4 select input channel
// - Control bit 3 is read-only done flag
// - Control bits 2..1 select conversion speed
// - Writing bit 0 high starts conversion
// - Seed approximation at 200h, update per bit
// - First trial at half reference, then refined
// - One channel at a time, changeable between
// - Ten setup clocks, four per bit, fifty
// - Conversion clock is CPU clock over four
// - On completion set done, store, go idle
// - Upper eight bits high, lower two low
// - New result overwrites previous result
// - Control register takes low-byte writes only; reads take any strobe
// - Control register decoded at word index f7h, byte offset 3dch
`timescale 1ns/1ps
module sarseq_top
  import sarseq_pkg::*;
#(
  parameter int RES_BITS = SARSEQ_RES_BITS,
  parameter int CPU_DIV  = SARSEQ_CPU_DIV
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [9:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cmp_hi,
  output logic [2:0]       mux_sel,
  output logic [1:0]       speed_sel,
  output logic [9:0]       dac_code,
  output logic             conv_busy
);
  // ==========================================================
  // Bus decode
  logic acc;
  logic sel_ctrl;
  logic sel_hi;
  logic sel_lo;
  logic ctrl_wr;
  logic byte_ok;

  assign acc      = psel && penable;
  assign sel_ctrl = (paddr == SARSEQ_CTRL_OFS);
  assign sel_hi   = (paddr == SARSEQ_RES_HI_OFS);
  assign sel_lo   = (paddr == SARSEQ_RES_LO_OFS);
  // Only the low byte lane reaches the control register
  assign byte_ok  = (pstrb == 4'h1);
  assign ctrl_wr  = acc && pwrite && sel_ctrl && byte_ok;
  assign pready   = 1'b1;
  // Unmapped, wide writes and writes to results are errors
  assign pslverr  = acc && (!(sel_ctrl || sel_hi || sel_lo) ||
                    (pwrite && !(sel_ctrl && byte_ok)));

  // ==========================================================
  // Control register and sequencer state
  sarseq_state_t st_q;
  sarseq_state_t st_d;
  logic [2:0]    ch_q;
  logic [2:0]    ch_d;
  logic [1:0]    spd_q;
  logic [1:0]    spd_d;
  logic          done_q;
  logic          done_d;
  logic [3:0]    cnt_q;
  logic [3:0]    cnt_d;
  logic [7:0]    res_hi_q;
  logic [7:0]    res_hi_d;
  logic [1:0]    res_lo_q;
  logic [1:0]    res_lo_d;
  logic          start;
  logic          tick;
  logic          seed;
  logic          step;
  logic          last;
  logic [9:0]    trial;

  // Start is ignored while busy so only one channel converts at a time
  assign start = ctrl_wr && pwdata[SARSEQ_START_BIT] && (st_q == SARSEQ_IDLE);

  always_comb begin
    st_d     = st_q;
    ch_d     = ch_q;
    spd_d    = spd_q;
    done_d   = done_q;
    cnt_d    = cnt_q;
    res_hi_d = res_hi_q;
    res_lo_d = res_lo_q;
    seed     = 1'b0;
    step     = 1'b0;
    // Channel and speed frozen during a conversion
    if (ctrl_wr && st_q == SARSEQ_IDLE) begin
      ch_d  = pwdata[SARSEQ_CH_MSB:SARSEQ_CH_LSB];
      spd_d = pwdata[SARSEQ_SPD_MSB:SARSEQ_SPD_LSB];
    end
    case (st_q)
      SARSEQ_IDLE: begin
        if (start) begin
          done_d = 1'b0;
          seed   = 1'b1;
          cnt_d  = 4'(SARSEQ_SETUP_CLKS - 1);
          st_d   = SARSEQ_SETUP;
        end
      end
      SARSEQ_SETUP: begin
        if (tick) begin
          if (cnt_q == 4'h0) begin
            cnt_d = 4'(SARSEQ_BIT_CLKS - 1);
            st_d  = SARSEQ_TRIAL;
          end else begin
            cnt_d = cnt_q - 4'h1;
          end
        end
      end
      SARSEQ_TRIAL: begin
        if (tick) begin
          if (cnt_q == 4'h0) begin
            // Decision at end of each four-clock bit slot
            cnt_d = 4'(SARSEQ_BIT_CLKS - 1);
            if (last) begin
              st_d = SARSEQ_STORE;
            end
            step = 1'b1;
          end else begin
            cnt_d = cnt_q - 4'h1;
          end
        end
      end
      SARSEQ_STORE: begin
        res_hi_d = trial[9:2];
        res_lo_d = trial[1:0];
        done_d   = 1'b1;
        st_d     = SARSEQ_IDLE;
      end
      default: begin
        st_d = SARSEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q     <= SARSEQ_IDLE;
      ch_q     <= SARSEQ_CTRL_RST[SARSEQ_CH_MSB:SARSEQ_CH_LSB];
      spd_q    <= SARSEQ_CTRL_RST[SARSEQ_SPD_MSB:SARSEQ_SPD_LSB];
      done_q   <= SARSEQ_CTRL_RST[SARSEQ_DONE_BIT];
      cnt_q    <= 4'h0;
      res_hi_q <= 8'h00;
      res_lo_q <= 2'h0;
    end else begin
      st_q     <= st_d;
      ch_q     <= ch_d;
      spd_q    <= spd_d;
      done_q   <= done_d;
      cnt_q    <= cnt_d;
      res_hi_q <= res_hi_d;
      res_lo_q <= res_lo_d;
    end
  end

  // ==========================================================
  // Conversion clock and approximation register
  sarseq_clkdiv #(
    .DIV (CPU_DIV)
  ) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (seed),
    .tick    (tick)
  );

  sarseq_sar #(
    .W (RES_BITS)
  ) u_sar (
    .pclk    (pclk),
    .presetn (presetn),
    .seed    (seed),
    .step    (step),
    .cmp_hi  (cmp_hi),
    .trial   (trial),
    .last    (last)
  );

  // ==========================================================
  // Read data, done bit reads back and is never written
  always_comb begin
    prdata = 32'h0000_0000;
    if (sel_ctrl) begin
      prdata[SARSEQ_CH_MSB:SARSEQ_CH_LSB]   = ch_q;
      prdata[SARSEQ_DONE_BIT]               = done_q;
      prdata[SARSEQ_SPD_MSB:SARSEQ_SPD_LSB] = spd_q;
    end else if (sel_hi) begin
      prdata[7:0] = res_hi_q;
    end else if (sel_lo) begin
      prdata[1:0] = res_lo_q;
    end
  end

  assign mux_sel   = ch_q;
  assign speed_sel = spd_q;
  assign dac_code  = trial;
  assign conv_busy = (st_q != SARSEQ_IDLE);
endmodule

/* File: hdl/sarseq_pkg.sv */
// Purpose: Constants shared by the SAR converter sequencer files
// Assumes: APB with 32-bit data, one word per register
// Notes:   Control index counts words, so its byte address is four times it
package sarseq_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] SARSEQ_CTRL_IDX   = 8'hf7;
  localparam logic [9:0] SARSEQ_CTRL_OFS   = {SARSEQ_CTRL_IDX, 2'h0};
  localparam logic [9:0] SARSEQ_RES_HI_OFS = 10'h0f8;
  localparam logic [9:0] SARSEQ_RES_LO_OFS = 10'h0fc;
  localparam logic [7:0] SARSEQ_CTRL_RST   = 8'h00;
  // ==========================================================
  // Control fields
  localparam int SARSEQ_CH_LSB    = 4;
  localparam int SARSEQ_CH_MSB    = 6;
  localparam int SARSEQ_DONE_BIT  = 3;
  localparam int SARSEQ_SPD_LSB   = 1;
  localparam int SARSEQ_SPD_MSB   = 2;
  localparam int SARSEQ_START_BIT = 0;
  // ==========================================================
  // Conversion timing in conversion clocks
  localparam int SARSEQ_RES_BITS   = 10;
  localparam int SARSEQ_SETUP_CLKS = 10;
  localparam int SARSEQ_BIT_CLKS   = 4;
  localparam int SARSEQ_CPU_DIV    = 4;
  localparam logic [9:0] SARSEQ_SEED = 10'h200;
  // ==========================================================
  // Sequencer states, Gray along setup, trial, store
  typedef enum logic [1:0] {
    SARSEQ_IDLE  = 2'b00,
    SARSEQ_SETUP = 2'b01,
    SARSEQ_TRIAL = 2'b11,
    SARSEQ_STORE = 2'b10
  } sarseq_state_t;
endpackage

/* File: hdl/sarseq_clkdiv.sv */
// Purpose: Conversion clock enable, one pulse per DIV pclk cycles
// Assumes: Single clock domain
// Notes:   Counter restarts on clear so each conversion is aligned
`timescale 1ns/1ps
module sarseq_clkdiv #(
  parameter int DIV = 4
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clear,
  output logic      tick
);
  // ==========================================================
  // Divider
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;

  always_comb begin
    if (clear || cnt_q == 8'(DIV - 1)) begin
      cnt_d = 8'h00;
    end else begin
      cnt_d = cnt_q + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign tick = !clear && (cnt_q == 8'(DIV - 1));
endmodule

/* File: hdl/sarseq_sar.sv */
// Purpose: Successive approximation register with trial bit pointer
// Assumes: Comparator output valid when step is pulsed
// Notes:   cmp_hi means input is above the trial level
`timescale 1ns/1ps
module sarseq_sar
  import sarseq_pkg::*;
#(
  parameter int W = 10
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         seed,
  input  wire logic         step,
  input  wire logic         cmp_hi,
  output logic [W-1:0]      trial,
  output logic              last
);
  // ==========================================================
  // Approximation and bit pointer
  logic [W-1:0] sar_q;
  logic [W-1:0] sar_d;
  logic [W-1:0] ptr_q;
  logic [W-1:0] ptr_d;

  always_comb begin
    sar_d = sar_q;
    ptr_d = ptr_q;
    if (seed) begin
      sar_d = W'(SARSEQ_SEED);
      ptr_d = W'(SARSEQ_SEED);
    end else if (step) begin
      // Keep or drop the bit on trial, then try the next lower one
      if (!cmp_hi) begin
        sar_d = sar_q & ~ptr_q;
      end
      ptr_d = ptr_q >> 1;
      sar_d = sar_d | (ptr_q >> 1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sar_q <= '0;
      ptr_q <= '0;
    end else begin
      sar_q <= sar_d;
      ptr_q <= ptr_d;
    end
  end

  assign trial = sar_q;
  assign last  = ptr_q[0];
endmodule

/* File: tb/sarseq_chk.sv */
// Purpose: Port assertions for the SAR sequencer
// Assumes: One pclk domain, presetn async active low
// Notes:   Done flag is rebuilt from conv_busy history
`timescale 1ns/1ps
module sarseq_chk #(
  parameter int RES_BITS = 10,
  parameter int CPU_DIV  = 4
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [9:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cmp_hi,
  input wire logic [2:0]  mux_sel,
  input wire logic [1:0]  speed_sel,
  input wire logic [9:0]  dac_code,
  input wire logic        conv_busy
);
  // ==========================================================
  // Helper state
  localparam int LO = 50 * CPU_DIV - 2;
  localparam int HI = 50 * CPU_DIV + 4;
  logic [8:0] cnt_q, cnt_d;
  logic       ran_q, ran_d;
  logic       wr_ctl, rd_ctl, acc;
  assign acc    = psel && penable;
  assign wr_ctl = acc && pwrite && paddr == 10'h3dc && pstrb == 4'h1;
  assign rd_ctl = acc && !pwrite && paddr == 10'h3dc;
  always_comb begin
    cnt_d = conv_busy ? cnt_q + 9'h001 : 9'h000;
    ran_d = ran_q | conv_busy;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 9'h000;
      ran_q <= 1'h0;
    end else begin
      cnt_q <= cnt_d;
      ran_q <= ran_d;
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_start; wr_ctl && pwdata[0] && !conv_busy |=> conv_busy && dac_code == 10'h200; endproperty
  a_start: assert property (p_start) else $error("start did not seed");
  property p_sel; wr_ctl && !conv_busy |=> mux_sel == $past(pwdata[6:4]) && speed_sel == $past(pwdata[2:1]); endproperty
  a_sel: assert property (p_sel) else $error("select fields wrong");
  property p_lock; wr_ctl && conv_busy |=> $stable(mux_sel) && $stable(speed_sel); endproperty
  a_lock: assert property (p_lock) else $error("select moved while busy");
  property p_len; $fell(conv_busy) |-> cnt_q >= LO && cnt_q <= HI; endproperty
  a_len: assert property (p_len) else $error("conversion length wrong");
  property p_max; conv_busy |-> cnt_q <= HI; endproperty
  a_max: assert property (p_max) else $error("conversion too long");
  property p_done; rd_ctl |-> prdata[3] == (ran_q && !conv_busy) && !prdata[0]; endproperty
  a_done: assert property (p_done) else $error("done flag wrong");
  property p_ro; acc && pwrite && (paddr == 10'h0f8 || paddr == 10'h0fc) |-> pslverr; endproperty
  a_ro: assert property (p_ro) else $error("result write accepted");
  property p_byte; acc && pwrite && paddr == 10'h3dc && pstrb != 4'h1 |-> pslverr ##1 $stable(mux_sel); endproperty
  a_byte: assert property (p_byte) else $error("wide control write accepted");
  property p_map; rd_ctl |-> pready && !pslverr; endproperty
  a_map: assert property (p_map) else $error("control not decoded");
  c_conv: cover property ($fell(conv_busy));
  c_err: cover property (acc && pslverr);
  c_lock: cover property (wr_ctl && conv_busy);
endmodule

bind sarseq_top sarseq_chk #(.RES_BITS(RES_BITS), .CPU_DIV(CPU_DIV)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .cmp_hi(cmp_hi), .mux_sel(mux_sel), .speed_sel(speed_sel),
  .dac_code(dac_code), .conv_busy(conv_busy));

/* File: tb/tb_sarseq_top.sv */
// Purpose: Directed APB tests for the SAR sequencer
// Assumes: Zero wait states, 40 MHz pclk
// Notes:   Comparator follows a target code held by the bench
`timescale 1ns/1ps
module tb_sarseq_top;
  // ==========================================================
  // Signals
  logic        pclk, presetn, psel, penable, pwrite, cmp_hi, pready, pslverr, conv_busy, rerr;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  pstrb;
  logic [2:0]  mux_sel;
  logic [1:0]  speed_sel;
  logic [9:0]  dac_code, tgt;
  int          n_fail, check_count, cyc;
  realtime     t0;
  sarseq_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmp_hi(cmp_hi), .mux_sel(mux_sel),
    .speed_sel(speed_sel), .dac_code(dac_code), .conv_busy(conv_busy));
  initial begin
    pclk = 1'h0;
    forever #12.5 pclk = ~pclk;
  end
  // Comparator answers a cycle late; trials last four ticks so it settles
  always @(posedge pclk) begin
    // Input pin taken as already set up for analog use
    cmp_hi <= dac_code <= tgt;
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail++;
      end_of_test();
    end
  end
  // ==========================================================
  // Tasks
  task automatic end_of_test();
    if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    {psel, penable, pwrite} <= {1'h1, 1'h0, w};
    {paddr, pwdata, pstrb} <= {a, d, s};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rdat = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic conv(input logic [7:0] d, input logic [9:0] t, input logic mid);
    int n;
    tgt <= t;
    // Channel goes in first, start follows in a second write
    xfer(1'h1, 10'h3dc, {24'h0, d & 8'hfe}, 4'h1);
    xfer(1'h1, 10'h3dc, {24'h0, d}, 4'h1);
    t0 = $realtime;
    @(negedge pclk);
    chk({conv_busy, mux_sel, dac_code}, {1'h1, d[6:4], 10'h200});
    if (mid) begin
      xfer(1'h1, 10'h3dc, 32'h71, 4'h1);
      xfer(1'h0, 10'h3dc, 32'h0, 4'h1);
      chk(rdat, {25'h0, d[6:4], 1'h0, d[2:1], 1'h0});
    end
    while (conv_busy !== 1'h0) @(posedge pclk);
    n = int'(($realtime - t0) / 25.0);
    chk(n >= 199 && n <= 204, 32'h1);
    xfer(1'h0, 10'h3dc, 32'h0, 4'h1);
    chk(rdat, {25'h0, d[6:4], 1'h1, d[2:1], 1'h0});
    xfer(1'h0, 10'h0f8, 32'h0, 4'h1);
    chk(rdat, {24'h0, t[9:2]});
    xfer(1'h0, 10'h0fc, 32'h0, 4'h1);
    chk(rdat, {30'h0, t[1:0]});
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    {paddr, pwdata, pstrb, tgt} = 56'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    xfer(1'h0, 10'h3dc, 32'h0, 4'h1);
    chk(rdat, 32'h0);
    for (int c = 0; c < 8; c++) begin
      xfer(1'h1, 10'h3dc, {25'h0, c[2:0], 1'h1, c[1:0], 1'h0}, 4'h1);
      @(negedge pclk);
      chk({mux_sel, speed_sel}, {c[2:0], c[1:0]});
    end
    xfer(1'h1, 10'h3dc, 32'h01, 4'h3);
    chk(rerr, 32'h1);
    xfer(1'h1, 10'h0f8, 32'h0, 4'h1);
    chk(rerr, 32'h1);
    xfer(1'h0, 10'h040, 32'h0, 4'h1);
    chk(rerr, 32'h1);
    xfer(1'h0, 10'h3dc, 32'h0, 4'h1);
    chk(rdat, 32'h76);
    chk(rerr, 32'h0);
    conv(8'h31, 10'h2a5, 1'h0);
    conv(8'h5d, 10'h0ff, 1'h1);
    conv(8'h73, 10'h3ff, 1'h0);
    conv(8'h01, 10'h000, 1'h0);
    end_of_test();
  end
endmodule
